// ==== rtl/pgtrn_pkg.sv ====
package pgtrn_pkg;

   // --------------------------------------------------------------
   // clock and timing
   // --------------------------------------------------------------
   localparam int SYS_CLK_HZ      = 10000000;
   localparam int HALF_SLOT_NS    = 312500;
   localparam int HALF_SLOT_CYC   = (HALF_SLOT_NS / 100);
   localparam int RETUNE_MIN_NS   = 224500;
   localparam int RETUNE_CYC      = (RETUNE_MIN_NS + 99) / 100;
   localparam int PHASE_LSB       = 12;
   localparam int PHASE_MSB_79    = 16;
   localparam int PHASE_MSB_23    = 15;
   localparam int CLK_W           = 28;

   // --------------------------------------------------------------
   // scan window and interval limits, in slots
   // --------------------------------------------------------------
   localparam int SLOT_US         = 625;
   localparam int R1_MAX_MS       = 1280;
   localparam int R2_MAX_MS       = 2560;
   localparam int R1_MAX_SLOTS    = R1_MAX_MS * 1000 / SLOT_US;
   localparam int R2_MAX_SLOTS    = R2_MAX_MS * 1000 / SLOT_US;
   localparam int VOICE_INTERVAL  = 6;
   localparam int WIN_ONE_VOICE   = 36;
   localparam int WIN_TWO_VOICE   = 54;
   localparam int TRAIN_LEN       = 16;
   localparam int HOPS_PER_SET    = 32;

   // --------------------------------------------------------------
   // repetition field codes
   // --------------------------------------------------------------
   localparam logic [1:0] CONTINUOUS_SCAN_MODE = 2'h0;
   localparam logic [1:0] SHORT_INTERVAL_MODE  = 2'h1;
   localparam logic [1:0] LONG_INTERVAL_MODE   = 2'h2;
   localparam logic [1:0] SCAN_REP_RESERVED    = 2'h3;

   typedef enum logic [2:0] {
      PGTRN_IDLE    = 3'h0,
      PGTRN_SCAN    = 3'h1,
      PGTRN_PAGE    = 3'h4,
      PGTRN_SLVRSP  = 3'h3,
      PGTRN_MSTRSP  = 3'h6
   } pgtrn_state_e;

   // one radio command to the hop kernel
   typedef struct packed {
      logic       txEn;
      logic       rxEn;
      logic       responseHop;
      logic [4:0] hopOffset;
      logic [4:0] hopPhase;
   } pgtrn_radio_s;

   // link manager settings for a page attempt
   typedef struct packed {
      logic [15:0] pageTimeout;
      logic [9:0]  trainRepeatCount;
      logic        reducedHop;
   } pgtrn_page_cfg_s;

endpackage

// ==== rtl/pgtrn_sync.sv ====
`timescale 1ns/100ps
// three-stage input synchroniser; a change counts once stages two and three agree
module pgtrn_sync (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      sync_out
);
   logic [2:0] stage_reg;
   logic       out_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stage_reg <= 3'h0;
         out_reg   <= 1'b0;
      end else begin
         stage_reg <= {stage_reg[1:0], async_in};
         if (stage_reg[1] == stage_reg[2]) begin
            out_reg <= stage_reg[2];
         end
      end
   end

   assign sync_out = out_reg;
endmodule

// ==== rtl/pgtrn_top.sv ====
`timescale 1ns/100ps
// Behaviour
// - listen-for-page entered from idle only; the connected input does not affect entry.
// - reserved voice slots interrupt scan windows.
// - with voice links, a scan window under 36 or 54 slots raises windowShort.
// - scan interval versus window picks repetition mode zero, one, two, or reserved code three above 2.56 s.
// - repetition mode advertised in the two-bit scan repetition field.
// - optional scan scheme allowed except after own inquiry response.
// - paging sends target access code on hops, listens between sends.
// - hop sequence from target address, phase from estimated peer clock.
// - two identity packets per transmit slot, at least 224.5 us retune.
// - receive slot listens on the two matching response hops.
// - new hop pair each transmit slot; 3200 hops per second.
// - one train covers 16 hops in 16 slots, 10 ms.
// - first train is f(k-8)..f(k+7), k from clock bits 16..12.
// - first train repeated configured count or until response.
// - train contents follow the current clock phase every 1.28 s.
// - second train is f(k-16)..f(k-9) and f(k+8)..f(k+15).
// - trains alternate, each repeated, until response or timeout.
// - response in any listen occasion enters master response.
// - reduced system uses one 16-hop train, phase from bits 15..12.
// - scan window covers 16 page frequencies on a single hop.
// - correlator trigger while the scan window is listening enters slave response.
module pgtrn_top
   import pgtrn_pkg::*;
#(
   parameter int SCAN_WIN_W = 12
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  scanStart,
   input  wire logic                  pageStart,
   input  wire logic                  abortReq,
   input  wire logic                  connected,
   input  wire logic                  afterInquiryResp,
   input  wire logic                  optScanReq,
   input  wire logic [1:0]            voiceLinks,
   input  wire logic [SCAN_WIN_W-1:0] scanWindow,
   input  wire logic [SCAN_WIN_W-1:0] scanInterval,
   input  wire logic                  voiceSlot,
   input  wire logic                  corrTrigger,
   input  wire logic                  respDetect,
   input  wire logic [CLK_W-1:0]      estimated_peer_clock,
   input  wire pgtrn_page_cfg_s       pageCfg,
   output pgtrn_radio_s               radioCmd,
   output logic [1:0]                 scan_repetition_field,
   output logic                       optScanEn,
   output logic                       scanning,
   output logic                       paging,
   output logic                       slaveResponse,
   output logic                       masterResponse,
   output logic                       pageTimedOut,
   output logic                       windowShort
);

   initial begin
      if (SCAN_WIN_W < 7 || SCAN_WIN_W > 16) begin
         $error("scan window width out of range");
      end
   end

   // --------------------------------------------------------------
   // asynchronous radio inputs
   // --------------------------------------------------------------
   logic corrSync;
   logic respSync;

   pgtrn_sync u_corr_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (corrTrigger),
      .sync_out (corrSync)
   );

   pgtrn_sync u_resp_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (respDetect),
      .sync_out (respSync)
   );

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      pgtrn_state_e           state;
      logic [10:0]            tickCnt;
      logic [1:0]             quarter;
      logic [SCAN_WIN_W-1:0]  slotInWin;
      logic [SCAN_WIN_W-1:0]  slotInIntv;
      logic [15:0]            timeout;
      logic [9:0]             repeatCount;
      logic [9:0]             repeatLeft;
      logic                   reduced;
      logic [3:0]             trainPos;
      logic                   trainB;
      logic                   respPrev;
      pgtrn_radio_s           radio;
      logic [1:0]             srField;
      logic                   optScan;
      logic                   timedOut;
      logic                   winShort;
      logic                   scanFlag;
      logic                   pageFlag;
      logic                   slvFlag;
      logic                   mstFlag;
   } pgtrn_regs_s;

   pgtrn_regs_s r_reg;
   pgtrn_regs_s r_next;

   logic       tick;
   logic       slotEdge;
   logic [4:0] phase;
   logic [4:0] trainOffset;
   logic [4:0] hopIdx;
   logic [1:0] srMode;
   logic [SCAN_WIN_W-1:0] winMin;

   // quarter-slot tick, 156.2 us
   assign tick     = (r_reg.tickCnt == 11'(HALF_SLOT_CYC / 2 - 1));
   assign slotEdge = tick && (r_reg.quarter == 2'h3);

   // phase source; reduced system uses four bits
   assign phase = r_reg.reduced
      ? {1'b0, estimated_peer_clock[PHASE_MSB_23:PHASE_LSB]}
      : estimated_peer_clock[PHASE_MSB_79:PHASE_LSB];

   // train A offset; train B skips the A hops
   // one hop per half slot; the receive slot repeats its transmit slot's pair,
   // so each train position pair walks eight fresh pairs through 16 slots
   always_comb begin
      hopIdx      = {1'b0, r_reg.trainPos[3:1], r_reg.quarter[1]};
      trainOffset = 5'(hopIdx[3:0]) - 5'h8;
      if (r_reg.trainB) begin
         trainOffset = hopIdx[3] ? 5'(hopIdx[2:0]) + 5'h8 : 5'(hopIdx[2:0]) - 5'h10;
      end
   end

   always_comb begin
      if (scanInterval == scanWindow) begin
         srMode = CONTINUOUS_SCAN_MODE;
      end else if (32'(scanInterval) <= R1_MAX_SLOTS) begin
         srMode = SHORT_INTERVAL_MODE;
      end else if (32'(scanInterval) <= R2_MAX_SLOTS) begin
         srMode = LONG_INTERVAL_MODE;
      end else begin
         srMode = SCAN_REP_RESERVED;
      end
   end

   // recommended window with voice; at least one train
   always_comb begin
      unique case (voiceLinks)
         2'h0:    winMin = SCAN_WIN_W'(TRAIN_LEN);
         2'h1:    winMin = SCAN_WIN_W'(WIN_ONE_VOICE);
         default: winMin = SCAN_WIN_W'(WIN_TWO_VOICE);
      endcase
   end

   // --------------------------------------------------------------
   // next-state logic
   // --------------------------------------------------------------
   always_comb begin
      r_next          = r_reg;
      r_next.respPrev = respSync;
      r_next.tickCnt  = tick ? 11'h0 : r_reg.tickCnt + 11'h1;
      if (tick) begin
         r_next.quarter = r_reg.quarter + 2'h1;
      end
      r_next.srField  = srMode;
      r_next.winShort = (scanWindow < winMin);
      r_next.radio    = '0;

      unique case (r_reg.state)
         PGTRN_IDLE: begin
            r_next.slotInWin  = '0;
            r_next.slotInIntv = '0;
            if (scanStart) begin
               r_next.state   = PGTRN_SCAN;
               r_next.optScan = optScanReq && !afterInquiryResp;
            end else if (pageStart) begin
               r_next.state       = PGTRN_PAGE;
               r_next.timeout     = pageCfg.pageTimeout;
               r_next.repeatCount = (pageCfg.trainRepeatCount == 10'h0)
                                    ? 10'h1 : pageCfg.trainRepeatCount;
               r_next.repeatLeft  = (pageCfg.trainRepeatCount == 10'h0)
                                    ? 10'h1 : pageCfg.trainRepeatCount;
               r_next.reduced     = pageCfg.reducedHop;
               r_next.trainPos    = '0;
               r_next.trainB      = 1'b0;
               r_next.timedOut    = 1'b0;
               // slot timing restarts at entry so the first train is whole
               r_next.tickCnt     = '0;
               r_next.quarter     = '0;
            end
         end

         PGTRN_SCAN: begin
            // listen on one hop for the window; voice slot wins
            r_next.radio.rxEn     = (r_reg.slotInWin < scanWindow) && !voiceSlot;
            r_next.radio.hopPhase = phase;
            if (slotEdge) begin
               r_next.slotInWin  = r_reg.slotInWin + SCAN_WIN_W'(1);
               r_next.slotInIntv = r_reg.slotInIntv + SCAN_WIN_W'(1);
               if (r_reg.slotInIntv + SCAN_WIN_W'(1) >= scanInterval) begin
                  r_next.slotInWin  = '0;
                  r_next.slotInIntv = '0;
               end
            end
            // trigger only counts inside the open window
            if (corrSync && r_reg.radio.rxEn) begin
               r_next.state = PGTRN_SLVRSP;
            end else if (abortReq) begin
               r_next.state = connected ? PGTRN_IDLE : PGTRN_IDLE;
            end
         end

         PGTRN_PAGE: begin
            // send in even slots of the train, listen in odd slots
            // one hop per half slot leaves about 244 us to retune
            // receive slot reuses the pair on the response hops
            r_next.radio.txEn        = !voiceSlot && !r_reg.trainPos[0];
            r_next.radio.rxEn        = !voiceSlot && r_reg.trainPos[0];
            r_next.radio.responseHop = r_reg.trainPos[0];
            r_next.radio.hopOffset   = r_reg.reduced ? 5'(hopIdx[3:0]) : trainOffset;
            r_next.radio.hopPhase    = phase;
            if (slotEdge) begin
               r_next.timeout = r_reg.timeout - 16'h1;
               // advance to a fresh pair every other slot
               r_next.trainPos = r_reg.trainPos + 4'h1;
               if (r_reg.trainPos == 4'hf) begin
                  if (r_reg.repeatLeft == 10'h1) begin
                     r_next.repeatLeft = r_reg.repeatCount;
                     r_next.trainB     = !r_reg.trainB && !r_reg.reduced;
                  end else begin
                     r_next.repeatLeft = r_reg.repeatLeft - 10'h1;
                  end
               end
            end
            if (respSync && !r_reg.respPrev) begin
               r_next.state = PGTRN_MSTRSP;
            end else if (slotEdge && r_reg.timeout <= 16'h1) begin
               r_next.state    = PGTRN_IDLE;
               r_next.timedOut = 1'b1;
            end else if (abortReq) begin
               r_next.state = PGTRN_IDLE;
            end
         end

         PGTRN_SLVRSP, PGTRN_MSTRSP: begin
            if (abortReq) begin
               r_next.state = PGTRN_IDLE;
            end
         end

         default: r_next.state = PGTRN_IDLE;
      endcase

      // leaving a substate must not key the radio for one more cycle
      if (r_next.state != r_reg.state) begin
         r_next.radio = '0;
      end
      r_next.scanFlag = (r_next.state == PGTRN_SCAN);
      r_next.pageFlag = (r_next.state == PGTRN_PAGE);
      r_next.slvFlag  = (r_next.state == PGTRN_SLVRSP);
      r_next.mstFlag  = (r_next.state == PGTRN_MSTRSP);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r_reg       <= '0;
         r_reg.state <= PGTRN_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign radioCmd              = r_reg.radio;
   assign scan_repetition_field = r_reg.srField;
   assign optScanEn             = r_reg.optScan;
   assign scanning              = r_reg.scanFlag;
   assign paging                = r_reg.pageFlag;
   assign slaveResponse         = r_reg.slvFlag;
   assign masterResponse        = r_reg.mstFlag;
   assign pageTimedOut          = r_reg.timedOut;
   assign windowShort           = r_reg.winShort;

endmodule

// ==== testbench/pgtrn_checker.sv ====
`timescale 1ns/100ps
module pgtrn_checker
   import pgtrn_pkg::*;
#(
   parameter int SCAN_WIN_W = 12
) (
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic                  scanStart,
   input wire logic                  pageStart,
   input wire logic                  abortReq,
   input wire logic [1:0]            voiceLinks,
   input wire logic [SCAN_WIN_W-1:0] scanWindow,
   input wire logic                  voiceSlot,
   input wire logic                  respDetect,
   input wire pgtrn_radio_s          radioCmd,
   input wire logic                  scanning,
   input wire logic                  paging,
   input wire logic                  slaveResponse,
   input wire logic                  masterResponse,
   input wire logic                  pageTimedOut,
   input wire logic                  windowShort
);
   // ------------------------------------------
   // state relations
   // ------------------------------------------
   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   logic idle;
   assign idle = !(scanning || paging || slaveResponse || masterResponse);

   sequence pageReq;
      idle && pageStart && !scanStart && !abortReq;
   endsequence
   sequence scanReq;
      idle && scanStart && !abortReq;
   endsequence
   sequence answered;
      paging && $rose(respDetect) && !abortReq;
   endsequence

   a_page_entry: assert property (pageReq |=> paging)
      else $error("page request not taken");
   a_scan_entry: assert property (scanReq |=> scanning)
      else $error("scan request not taken");
   a_abort_idle: assert property (abortReq |=> !paging && !scanning)
      else $error("abort did not return to idle");
   a_master_resp: assert property (answered |-> ##[1:10] masterResponse)
      else $error("response not followed by master response");
   a_leave_page: assert property ($rose(masterResponse) |-> $past(paging))
      else $error("master response not entered from paging");
   a_slave_resp: assert property ($rose(slaveResponse) |-> $past(scanning))
      else $error("slave response not entered from scanning");
   a_one_state: assert property (
      $onehot0({scanning, paging, slaveResponse, masterResponse}))
      else $error("more than one substate active");
   a_voice_gap: assert property (voiceSlot |=> !(radioCmd.txEn || radioCmd.rxEn))
      else $error("radio active in reserved voice slot");
   a_tx_paging: assert property (radioCmd.txEn |-> paging && !radioCmd.rxEn)
      else $error("transmit outside paging");
   a_rx_response: assert property (paging && radioCmd.rxEn |-> radioCmd.responseHop)
      else $error("page listen not on response hop");
   a_timeout_stop: assert property ($rose(pageTimedOut) |-> !paging && $past(paging))
      else $error("timeout did not end paging");
   // registered once, so inputs must have held over the last edge
   a_short_window: assert property (
      !$past(rst) && $stable(voiceLinks) && $stable(scanWindow)
      |-> windowShort == (scanWindow < ((voiceLinks == 2'h0) ? TRAIN_LEN :
          (voiceLinks == 2'h1) ? WIN_ONE_VOICE : WIN_TWO_VOICE)))
      else $error("short window flag wrong");
endmodule

bind pgtrn_top pgtrn_checker #(.SCAN_WIN_W(SCAN_WIN_W)) chk (.*);

// ==== testbench/pgtrn_peer.sv ====
`timescale 1ns/100ps
module pgtrn_peer
   import pgtrn_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire pgtrn_radio_s radioCmd,
   input  wire logic         answerOn,
   input  wire logic [4:0]   listenHop,
   input  wire logic         pageSend,
   output logic              respDetect,
   output logic              corrTrigger
);
   // ------------------------------------------
   // peer scanning on one hop
   // ------------------------------------------
   logic heard;
   // answer only on paired response hop
   always @(posedge sys_clk) begin
      if (!answerOn) begin
         heard <= 1'b0;
         respDetect <= 1'b0;
      end else begin
         if (radioCmd.txEn && radioCmd.hopOffset == listenHop) heard <= 1'b1;
         if (heard && radioCmd.rxEn && radioCmd.responseHop && radioCmd.hopOffset == listenHop)
            respDetect <= 1'b1;
      end
   end
   // page from peer reaches the correlator
   always @(posedge sys_clk) corrTrigger <= pageSend;
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench
   import pgtrn_pkg::*;
;
   localparam int SLOT_CYC = 4 * (HALF_SLOT_CYC / 2);
   logic            sys_clk, rst, scanStart, pageStart, abortReq, connected;
   logic            afterInquiryResp, optScanReq, voiceSlot, answerOn, pageSend;
   logic [1:0]      voiceLinks, scan_repetition_field;
   logic [12:0]     scanWindow, scanInterval;
   logic [CLK_W-1:0] estimated_peer_clock;
   logic [4:0]      listenHop;
   logic            corrTrigger, respDetect, optScanEn, scanning, paging;
   logic            slaveResponse, masterResponse, pageTimedOut, windowShort;
   pgtrn_page_cfg_s pageCfg;
   pgtrn_radio_s    radioCmd;
   int              errors = 0;
   int              comparisons = 0;

   pgtrn_top #(.SCAN_WIN_W(13)) DUT (.*);
   pgtrn_peer PEER (.*);

   always #50 sys_clk = ~sys_clk;

   // ------------------------------------------
   // shared tasks
   // ------------------------------------------
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic goIdle();
      @(negedge sys_clk) abortReq = 1'b1;
      @(negedge sys_clk) abortReq = 1'b0;
   endtask
   task automatic startPage(logic [15:0] tmo, logic red);
      // peer scans continuously, so one repetition per train is enough
      pageCfg = '{pageTimeout: tmo, trainRepeatCount: 10'h001, reducedHop: red};
      pageStart = 1'b1;
      @(negedge sys_clk) pageStart = 1'b0;
   endtask

   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   task automatic test_scan_modes();
      logic [12:0] win [4] = '{13'h0010, 13'h0024, 13'h0024, 13'h000f};
      logic [12:0] ivl [4] = '{13'h0010, 13'h0800, 13'h1000, 13'h1001};
      for (int i = 0; i < 4; i++) begin
         @(negedge sys_clk);
         scanWindow = win[i];
         scanInterval = ivl[i];
         voiceLinks = 2'(i % 3);
         afterInquiryResp = i[0];
         connected = i[1];
         scanStart = 1'b1;
         @(negedge sys_clk) scanStart = 1'b0;
         repeat (4) @(negedge sys_clk);
         check("scanning", scanning, 1'b1);
         check("repetition field", scan_repetition_field, 16'(i));
         check("window short", windowShort, i >= 2);
         check("optional scan", optScanEn, !i[0]);
         goIdle();
      end
      $display("test scan modes done");
   endtask

   task automatic test_scan_trigger();
      int n;
      scanWindow = 13'h0010;
      scanInterval = 13'h0010;
      voiceLinks = 2'h0;
      scanStart = 1'b1;
      @(negedge sys_clk) scanStart = 1'b0;
      for (n = 0; n < 2 * SLOT_CYC && radioCmd.rxEn !== 1'b1; n++) @(negedge sys_clk);
      check("scan listening", radioCmd.rxEn, 1'b1);
      voiceSlot = 1'b1;
      @(negedge sys_clk) check("voice slot gap", radioCmd.rxEn, 1'b0);
      voiceSlot = 1'b0;
      repeat (2) @(negedge sys_clk);
      pageSend = 1'b1;
      for (n = 0; n < 20 && slaveResponse !== 1'b1; n++) @(negedge sys_clk);
      check("slave response", {slaveResponse, scanning}, 2'b10);
      pageSend = 1'b0;
      goIdle();
      $display("test scan trigger done");
   endtask

   task automatic test_page_response();
      logic [4:0] seenHop [$];
      logic [4:0] phase;
      int n;
      estimated_peer_clock = 28'h0015000;
      answerOn = 1'b1;
      listenHop = 5'h19;
      startPage(16'h0100, 1'b0);
      check("paging", paging, 1'b1);
      for (n = 0; n < 3 * SLOT_CYC && masterResponse !== 1'b1; n++) begin
         @(negedge sys_clk);
         if (radioCmd.txEn === 1'b1 &&
             (seenHop.size() == 0 || seenHop[$] !== radioCmd.hopOffset)) begin
            seenHop.push_back(radioCmd.hopOffset);
            phase = radioCmd.hopPhase;
         end
      end
      check("first hop", seenHop[0], 5'h18);
      check("second hop", seenHop[1], 5'h19);
      check("hop phase", phase, 5'h15);
      check("master response", {masterResponse, paging}, 2'b10);
      answerOn = 1'b0;
      goIdle();
      $display("test page response done");
   endtask

   task automatic test_page_timeout();
      int n;
      startPage(16'h0004, 1'b0);
      pageCfg.pageTimeout = 16'h0001;
      for (n = 0; n < 6 * SLOT_CYC && pageTimedOut !== 1'b1; n++) @(negedge sys_clk);
      check("timed out", {pageTimedOut, paging}, 2'b10);
      check("timeout span", n >= 3 * SLOT_CYC && n <= 5 * SLOT_CYC, 1'b1);
      goIdle();
      startPage(16'h0100, 1'b1);
      @(negedge sys_clk) check("timeout cleared", pageTimedOut, 1'b0);
      check("reduced phase", radioCmd.hopPhase, 5'h05);
      check("reduced first hop", {radioCmd.txEn, radioCmd.hopOffset}, 6'h20);
      goIdle();
      $display("test page timeout done");
   endtask

   // ------------------------------------------
   // sequence and watchdog
   // ------------------------------------------
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      {scanStart, pageStart, abortReq, connected, afterInquiryResp} = '0;
      {optScanReq, voiceSlot, answerOn, pageSend} = 4'h1 << 3;
      voiceLinks = 2'h0;
      scanWindow = 13'h0010;
      scanInterval = 13'h0010;
      estimated_peer_clock = '0;
      listenHop = 5'h00;
      pageCfg = '0;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      check("idle after reset", {scanning, paging, masterResponse, radioCmd.txEn}, 4'h0);
      test_scan_modes();
      test_scan_trigger();
      test_page_response();
      test_page_timeout();
      complete_run();
   end
   // longest path is about six slots; twelve leaves margin
   initial begin
      repeat (12 * SLOT_CYC) @(posedge sys_clk);
      errors++;
      complete_run();
   end
endmodule
